// *** design/swin_pkg.sv ***
package swin_pkg;
  // window geometry
  localparam int SWIN_TAPS  = 24;
  localparam int SWIN_SEL_W = 4;
  localparam int SWIN_MAX_LANES = 8;

  // register indices; byte address is four times the index
  localparam logic [9:0] SWIN_IDX_POS_LO = 10'h02c;
  localparam logic [9:0] SWIN_IDX_POS_MID = 10'h02d;
  localparam logic [9:0] SWIN_IDX_POS_HI = 10'h02e;
  localparam logic [9:0] SWIN_IDX_CTRL = 10'h030;

  // control register fields
  localparam int SWIN_CTRL_SEL_LSB = 0;
  localparam int SWIN_CTRL_FINE_BIT = 4;
  localparam int SWIN_CTRL_ENC64_BIT = 5;
  localparam int SWIN_CTRL_LANES_LSB = 8;

  // reset values
  localparam logic [3:0] SWIN_RST_SEL = 4'h0;
  localparam logic SWIN_RST_FINE = 1'b1;
  localparam logic SWIN_RST_ENC64 = 1'b0;
  localparam logic [3:0] SWIN_RST_LANES = 4'h8;
  localparam logic [23:0] SWIN_RST_STATUS = 24'hffffff;

  // frame counter periods in device clock cycles
  localparam logic [15:0] SWIN_LMFC_PERIOD = 16'h0020;
  localparam logic [15:0] SWIN_LEMC_PERIOD = 16'h0040;
endpackage : swin_pkg

// *** design/swin_pos_detect.sv ***
`timescale 1ns/1ps
module swin_pos_detect
  import swin_pkg::*;
#(
  parameter int TAPS = SWIN_TAPS
) (
  input  wire logic            clk,
  input  wire logic            reset_n,
  input  wire logic [TAPS-1:0] tapSample,
  output logic      [TAPS-1:0] positionStatus
);
  typedef struct packed {
    logic [TAPS-1:0] status;
  } swin_det_s;

  swin_det_s q;
  swin_det_s d;
  logic      edgeInWindow;

  // a position is risky where a neighbour sampled a different level
  function automatic logic riskAt(input logic [TAPS-1:0] t,
                                  input int i);
    if (i == 0 || i == TAPS - 1) begin
      return 1'b1; // ends cannot be judged
    end
    return (t[i] != t[i-1]) || (t[i] != t[i+1]);
  endfunction : riskAt

  // only a window that holds the edge carries position information
  assign edgeInWindow = (tapSample != '0) && (tapSample != '1);

  // refresh on every edge seen, so reads track drift
  always_comb begin
    d = q;
    if (edgeInWindow) begin
      for (int i = 0; i < TAPS; i++) begin
        d.status[i] = riskAt(tapSample, i);
      end
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      q.status <= SWIN_RST_STATUS;
    end else begin
      q <= d;
    end
  end

  assign positionStatus = q.status;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  a_status_refresh: assert property (
    edgeInWindow && tapSample[1] != tapSample[2] |=> positionStatus[1])
    else $error("status not refreshed on edge in window");

  a_risk_clear: assert property (
    edgeInWindow && tapSample[4] == tapSample[3]
      && tapSample[4] == tapSample[5] |=> !positionStatus[4])
    else $error("stable position not marked valid");
endmodule : swin_pos_detect

// *** design/swin_frame_counter.sv ***
`timescale 1ns/1ps
module swin_frame_counter
  import swin_pkg::*;
#(
  parameter int CW = 16
) (
  input  wire logic          clk,
  input  wire logic          reset_n,
  input  wire logic          clear,
  input  wire logic [CW-1:0] period,
  output logic      [CW-1:0] count,
  output logic               boundary
);
  typedef struct packed {
    logic [CW-1:0] cnt;
    logic          bnd;
  } swin_cnt_s;

  swin_cnt_s q;
  swin_cnt_s d;

  // a captured reference restarts the frame phase deterministically
  always_comb begin
    d = q;
    d.bnd = 1'b0;
    if (clear) begin
      d.cnt = '0;
      d.bnd = 1'b1;
    end else if (q.cnt >= period - CW'(1)) begin
      d.cnt = '0;
      d.bnd = 1'b1;
    end else begin
      d.cnt = q.cnt + CW'(1);
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign count = q.cnt;
  assign boundary = q.bnd;
endmodule : swin_frame_counter

// *** design/swin_capture_window.sv ***
// Behaviour
// - report sysref position as per-position status
// - one means risky, zero means valid
// - sample sysref at a selected delayed instance
// - select field holds the chosen bit index
// - 24 status positions, select reaches 0..15
// - end positions 0 and 23 read one
// - step bit chooses coarse or fine spacing
// - 8b/10b and 64b/66b, at most 8 lanes
// - 8b/10b formats stay JESD204B compatible
// - 64b/66b block sync uses sync header
`timescale 1ns/1ps
module swin_capture_window
  import swin_pkg::*;
#(
  parameter int          TAPS        = SWIN_TAPS,
  parameter int          LANES       = SWIN_MAX_LANES,
  parameter logic [15:0] LMFC_PERIOD = SWIN_LMFC_PERIOD,
  parameter logic [15:0] LEMC_PERIOD = SWIN_LEMC_PERIOD
) (
  input  wire logic             clk,
  input  wire logic             reset_n,
  input  wire logic             psel,
  input  wire logic             penable,
  input  wire logic             pwrite,
  input  wire logic [11:0]      paddr,
  input  wire logic [31:0]      pwdata,
  output logic      [31:0]      prdata,
  output logic                  pready,
  output logic                  pslverr,
  input  wire logic [TAPS-1:0]  sysrefTap,
  input  wire logic             syncReq_n,
  output logic                  fineDelayStep,
  output logic                  sysrefCapture,
  output logic      [15:0]      frameCount,
  output logic                  frameBoundary,
  output logic                  encode64b66b,
  output logic      [LANES-1:0] laneEnable,
  output logic                  codeGroupSyncReq,
  output logic                  blockSyncByHeader
);
  typedef struct packed {
    logic [TAPS-1:0] tap;
    logic [3:0]      sel;
    logic            fine;
    logic            enc64;
    logic [3:0]      lanes;
    logic            selPrev;
    logic            capture;
    logic [31:0]     rdata;
    logic            err;
  } swin_top_s;

  swin_top_s       q;
  swin_top_s       d;
  logic [TAPS-1:0] positionStatus;
  logic            setupPhase;
  logic            accessPhase;
  logic            ctrlWrite;
  logic            selTap;

  // word index of an address, taken from bits 11..2 whatever the low bits
  function automatic logic [9:0] wordIndex(input logic [11:0] a);
    return a[11:2];
  endfunction : wordIndex

  function automatic logic isMapped(input logic [11:0] a);
    logic [9:0] i;
    i = wordIndex(a);
    return (a[1:0] == 2'b00) && (i == SWIN_IDX_POS_LO
      || i == SWIN_IDX_POS_MID || i == SWIN_IDX_POS_HI
      || i == SWIN_IDX_CTRL);
  endfunction : isMapped

  // lane count held in 1..LANES; zero or too many are clamped
  function automatic logic [3:0] clampLanes(input logic [3:0] n);
    if (n == 4'h0) begin
      return 4'h1;
    end
    if (n > 4'(LANES)) begin
      return 4'(LANES);
    end
    return n;
  endfunction : clampLanes

  function automatic logic [LANES-1:0] laneMask(input logic [3:0] n);
    logic [LANES-1:0] m;
    m = '0;
    for (int i = 0; i < LANES; i++) begin
      m[i] = (4'(i) < n);
    end
    return m;
  endfunction : laneMask

  // read data assembled in the setup cycle so prdata is a flop
  function automatic logic [31:0] readWord(input logic [11:0] a,
                                           input swin_top_s s,
                                           input logic [TAPS-1:0] st);
    logic [31:0] w;
    w = 32'h0;
    case (wordIndex(a))
      SWIN_IDX_POS_LO: begin
        w[7:0] = st[7:0];
      end
      SWIN_IDX_POS_MID: begin
        w[7:0] = st[15:8];
      end
      SWIN_IDX_POS_HI: begin
        w[7:0] = st[23:16];
      end
      SWIN_IDX_CTRL: begin
        w[SWIN_CTRL_SEL_LSB +: 4] = s.sel;
        w[SWIN_CTRL_FINE_BIT] = s.fine;
        w[SWIN_CTRL_ENC64_BIT] = s.enc64;
        w[SWIN_CTRL_LANES_LSB +: 4] = s.lanes;
      end
      default: begin
        w = 32'h0;
      end
    endcase
    if (a[1:0] != 2'b00) begin
      w = 32'h0;
    end
    return w;
  endfunction : readWord

  // apb phases; one wait-free access after a decoding setup
  assign setupPhase = psel && !penable;
  assign accessPhase = psel && penable;
  assign ctrlWrite = accessPhase && pwrite && paddr[1:0] == 2'b00
    && wordIndex(paddr) == SWIN_IDX_CTRL;

  // delayed instance picked by the select field; only 0..15 reachable
  assign selTap = q.tap[q.sel];

  // next-state logic for all block state
  always_comb begin
    d = q;
    d.tap = sysrefTap;
    d.selPrev = selTap;
    // rising sysref at the chosen instance restarts the frame clock
    d.capture = selTap && !q.selPrev;
    if (setupPhase) begin
      d.rdata = readWord(paddr, q, positionStatus);
      // status bytes are read-only; a write there is an error
      d.err = !isMapped(paddr)
        || (pwrite && wordIndex(paddr) != SWIN_IDX_CTRL);
    end
    if (ctrlWrite) begin
      d.sel = pwdata[SWIN_CTRL_SEL_LSB +: 4];
      d.fine = pwdata[SWIN_CTRL_FINE_BIT];
      d.enc64 = pwdata[SWIN_CTRL_ENC64_BIT];
      d.lanes = clampLanes(pwdata[SWIN_CTRL_LANES_LSB +: 4]);
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      q.tap <= '0;
      q.sel <= SWIN_RST_SEL;
      q.fine <= SWIN_RST_FINE;
      q.enc64 <= SWIN_RST_ENC64;
      q.lanes <= SWIN_RST_LANES;
      q.selPrev <= 1'b0;
      q.capture <= 1'b0;
      q.rdata <= 32'h0;
      q.err <= 1'b0;
    end else begin
      q <= d;
    end
  end

  // status works on the registered taps, one cycle behind the pins
  swin_pos_detect #(
    .TAPS (TAPS)
  ) u_detect (
    .clk            (clk),
    .reset_n        (reset_n),
    .tapSample      (q.tap),
    .positionStatus (positionStatus)
  );

  // frame or extended multiblock phase, period by encoding
  swin_frame_counter #(
    .CW (16)
  ) u_frame (
    .clk      (clk),
    .reset_n  (reset_n),
    .clear    (q.capture),
    .period   (q.enc64 ? LEMC_PERIOD : LMFC_PERIOD),
    .count    (frameCount),
    .boundary (frameBoundary)
  );

  // bus answers
  assign pready = accessPhase;
  assign prdata = q.rdata;
  assign pslverr = accessPhase && q.err;

  // link-side controls
  assign fineDelayStep = q.fine;
  assign sysrefCapture = q.capture;
  assign encode64b66b = q.enc64;
  assign laneEnable = laneMask(q.lanes);
  // 8b/10b keeps the classic sync handshake for older receivers
  assign codeGroupSyncReq = !q.enc64 && !syncReq_n;
  // 64b/66b aligns on the sync header, so the handshake is ignored
  assign blockSyncByHeader = q.enc64;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  sequence s_sel_rise;
    selTap && !q.selPrev;
  endsequence

  sequence s_ctrl_write;
    ctrlWrite;
  endsequence

  a_capture_edge: assert property (
    s_sel_rise |=> sysrefCapture ##1 frameCount == 16'h0000)
    else $error("sysref rise at chosen tap not captured");

  a_capture_cause: assert property (
    sysrefCapture |-> $past(selTap) && !$past(q.selPrev))
    else $error("capture without rise at chosen tap");

  a_sel_write: assert property (
    s_ctrl_write |=> q.sel == $past(pwdata[3:0]))
    else $error("select field not taken from write");

  a_fine_write: assert property (
    s_ctrl_write |=> fineDelayStep == $past(pwdata[4]))
    else $error("step bit not taken from write");

  a_end_bits: assert property (
    positionStatus[0] && positionStatus[23])
    else $error("end positions not set");

  a_lane_limit: assert property (
    q.lanes >= 4'h1 && q.lanes <= 4'h8 && !laneEnable[0] == 1'b0)
    else $error("lane count out of range");

  a_hdr_sync: assert property (
    encode64b66b |-> blockSyncByHeader && !codeGroupSyncReq)
    else $error("64b/66b mode used the sync handshake");

  a_legacy_sync: assert property (
    !encode64b66b && !syncReq_n |-> codeGroupSyncReq)
    else $error("8b/10b sync request not passed on");

  a_status_read: assert property (
    setupPhase && paddr == 12'h0b0 |=> prdata[7:0]
      == $past(positionStatus[7:0]) && prdata[31:8] == 24'h0)
    else $error("low status byte read wrong");

  a_bad_addr: assert property (
    setupPhase && !isMapped(paddr) ##1 accessPhase |-> pslverr)
    else $error("unmapped access not flagged");

  sequence s_ctrl_read;
    setupPhase && !pwrite && paddr[1:0] == 2'b00
      && wordIndex(paddr) == SWIN_IDX_CTRL;
  endsequence

  sequence s_ro_write;
    setupPhase && pwrite && wordIndex(paddr) != SWIN_IDX_CTRL;
  endsequence

  // a rise gives exactly one pulse, so a level cannot restart frames
  a_capture_once: assert property (
    sysrefCapture |=> !sysrefCapture)
    else $error("capture pulse lasted more than one cycle");

  // without an edge in the window the last reading must stand
  a_status_hold: assert property (
    (q.tap == '0 || q.tap == '1) |=> $stable(positionStatus))
    else $error("status changed with no edge in window");

  // software must see the select and step it programmed
  a_ctrl_readback: assert property (
    s_ctrl_read |=> prdata[3:0] == $past(q.sel)
      && prdata[4] == $past(q.fine))
    else $error("control read back wrong");

  a_ro_write: assert property (
    s_ro_write ##1 accessPhase |-> pslverr)
    else $error("write to status not refused");

  a_frame_wrap: assert property (
    frameBoundary |-> frameCount == 16'h0000)
    else $error("frame boundary away from count zero");

  // a free-running frame phase wraps on its own period too
  a_period_wrap: assert property (
    !encode64b66b && !sysrefCapture
      && frameCount == LMFC_PERIOD - 16'h0001 |=> frameBoundary)
    else $error("frame counter missed its wrap");

  a_lane_count: assert property (
    $countones(laneEnable) == int'(q.lanes))
    else $error("lane mask does not match lane count");
endmodule : swin_capture_window

// *** bench/swin_sysref_model.sv ***
`timescale 1ns/1ps
// sysref source as seen through the external tapped delay line
module swin_sysref_model
  import swin_pkg::*;
(
  input  wire logic                 clk,
  input  wire logic                 reset_n,
  input  wire logic                 fire,
  input  wire logic [4:0]           edgePos,
  output logic      [SWIN_TAPS-1:0] sysrefTap
);
  logic [2:0] phase;

  // one mixed window, three cycles high, then low so the next rise is clean
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      phase     <= 3'h0;
      sysrefTap <= '0;
    end else if (fire) begin
      phase <= 3'h1;
      for (int i = 0; i < SWIN_TAPS; i++) begin
        sysrefTap[i] <= (i >= edgePos);
      end
    end else if (phase != 3'h0) begin
      phase     <= (phase == 3'h4) ? 3'h0 : phase + 3'h1;
      sysrefTap <= (phase == 3'h4) ? '0 : '1;
    end
  end
endmodule : swin_sysref_model

// *** bench/swin_capture_window_tb.sv ***
`timescale 1ns/1ps
module swin_capture_window_tb
  import swin_pkg::*;
;
  localparam logic [11:0] ALO  = {SWIN_IDX_POS_LO, 2'b00};
  localparam logic [11:0] AMID = {SWIN_IDX_POS_MID, 2'b00};
  localparam logic [11:0] AHI  = {SWIN_IDX_POS_HI, 2'b00};
  localparam logic [11:0] ACT  = {SWIN_IDX_CTRL, 2'b00};
  logic clk = 0, reset_n = 0, psel = 0, penable = 0, pwrite = 0;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, r = 32'hec90, cyc = 0, t0 = 0;
  logic        pready, pslverr, syncReq_n = 1, fire = 0, capSeen = 0;
  logic [4:0]  edgePos = 5'h1;
  logic [23:0] tap, st;
  logic [15:0] frameCount;
  logic [7:0]  laneEnable;
  logic        fineDelayStep, sysrefCapture, frameBoundary;
  logic        encode64b66b, codeGroupSyncReq, blockSyncByHeader;
  logic [33:0] apbQ[$];
  logic [31:0] capQ[$];
  int          n_mismatch = 0, checks_done = 0, tick = 0;

  always #12.5 clk = ~clk;

  swin_capture_window dut (.clk(clk), .reset_n(reset_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .sysrefTap(tap),
    .syncReq_n(syncReq_n), .fineDelayStep(fineDelayStep),
    .sysrefCapture(sysrefCapture), .frameCount(frameCount),
    .frameBoundary(frameBoundary), .encode64b66b(encode64b66b),
    .laneEnable(laneEnable), .codeGroupSyncReq(codeGroupSyncReq),
    .blockSyncByHeader(blockSyncByHeader));

  swin_sysref_model src (.clk(clk), .reset_n(reset_n), .fire(fire),
    .edgePos(edgePos), .sysrefTap(tap));

  function automatic logic [31:0] lfsr(input logic [31:0] x);
    lfsr = {x[30:0], 1'b0} ^ (x[31] ? 32'h04c11db7 : 32'h0);
  endfunction : lfsr

  // both ends and the two positions that straddle the edge are risky
  function automatic logic [23:0] expStat(input int p);
    logic [23:0] s;
    s = 24'h800001;
    s[p-1] = 1'b1;
    s[p] = 1'b1;
    expStat = s;
  endfunction : expStat

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task tally_and_finish;
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : tally_and_finish

  // apb master: hold the request until pready is seen at a rising edge
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d, input logic e,
                     input logic [31:0] x);
    apbQ.push_back({~w, e, x});
    @(posedge clk);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  // result watcher: each result takes the oldest note
  always @(posedge clk) begin
    if (fire) t0 = cyc;
    if (psel && penable && pready) begin
      if (apbQ.size() == 0) check(1, 0);
      else begin
        logic [33:0] n;
        n = apbQ.pop_front();
        check(pslverr, n[32]);
        if (n[33]) check(prdata, n[31:0]);
      end
    end
    if (sysrefCapture === 1'b1) begin
      if (capQ.size() == 0) check(1, 0);
      else check(cyc - t0, capQ.pop_front());
      capSeen = 1;
    end else if (capSeen) begin
      // the counter is cleared by the registered pulse, one cycle on
      check(frameBoundary, 1);
      check(frameCount, 0);
      capSeen = 0;
    end
    cyc++;
    tick++;
    if (tick > 8000) begin
      n_mismatch++;
      tally_and_finish();
    end
  end

  initial begin
    int p;
    int s;
    logic [3:0] ln;
    repeat (8) @(posedge clk);
    reset_n <= 1'b1;
    // reset values and read-only refusals
    apb(0, ALO, 0, 0, 32'hff);
    apb(0, AMID, 0, 0, 32'hff);
    apb(0, AHI, 0, 0, 32'hff);
    apb(0, ACT, 0, 0, 32'h810);
    apb(0, 12'h0bc, 0, 1, 32'h0);
    apb(0, 12'h0b1, 0, 1, 32'h0);
    apb(1, AHI, 32'h0, 1, 32'h0);
    apb(0, AHI, 0, 0, 32'hff);
    check(laneEnable, 8'hff);
    $display("test reset_and_refusals done");
    // control field round trip; lane counts clamp to 1..8
    for (int i = 0; i < 4; i++) begin
      r = lfsr(r);
      ln = (i == 0) ? 4'h0 : (i == 1) ? 4'h3 : (i == 2) ? 4'h8 : 4'hc;
      @(posedge clk);
      syncReq_n <= r[6];
      apb(1, ACT, {20'h0, ln, 2'b00, i[0], r[4:0]}, 0, 32'h0);
      ln = (ln == 0) ? 4'h1 : (ln > 8) ? 4'h8 : ln;
      apb(0, ACT, 0, 0, {20'h0, ln, 2'b00, i[0], r[4:0]});
      @(negedge clk);
      check(fineDelayStep, r[4]);
      check(laneEnable, (9'h1 << ln) - 9'h1);
      check(blockSyncByHeader, i[0]);
      check(encode64b66b, i[0]);
      check(codeGroupSyncReq, !i[0] && !r[6]);
    end
    $display("test control_fields done");
    // capture at random select and edge; the first pass uses select 15, edge 16
    for (int k = 0; k < 8; k++) begin
      r = lfsr(r);
      s = (k == 0) ? 15 : r[3:0];
      p = (k == 0) ? 16 : 1 + (r[15:8] % 23);
      apb(1, ACT, 32'h810 | s, 0, 32'h0);
      capQ.push_back((s >= p) ? 3 : 4);
      @(posedge clk);
      edgePos <= p[4:0];
      fire    <= 1'b1;
      @(posedge clk);
      fire    <= 1'b0;
      repeat (8) @(posedge clk);
      st = expStat(p);
      apb(0, ALO, 0, 0, st[7:0]);
      apb(0, AMID, 0, 0, st[15:8]);
      apb(0, AHI, 0, 0, st[23:16]);
    end
    repeat (4) @(posedge clk);
    check(capQ.size(), 0);
    $display("test sysref_capture done");
    tally_and_finish();
  end
endmodule : swin_capture_window_tb
